// >>> rtl/dcad_bank_if.sv
// dcad_bank_if: row open/close events between decoder and bank tracker
`timescale 1ns/1ps
`default_nettype none
interface dcad_bank_if
  import dcad_pkg::*;
;
  logic              act;
  logic              pre;
  logic              pre_all;
  logic [BANK_W-1:0] bank;
  logic              any_open;

  modport ctrl (output act, output pre, output pre_all, output bank, input any_open);
  modport trk  (input act, input pre, input pre_all, input bank, output any_open);
endinterface : dcad_bank_if
`default_nettype wire

// >>> rtl/dcad_bank_trk.sv
// dcad_bank_trk: open-row flag per bank, feeds the power-down choice
`timescale 1ns/1ps
`default_nettype none
module dcad_bank_trk
  import dcad_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic clk_en_i,
  dcad_bank_if.trk  bank_if
);
  logic [NBANK-1:0] open_ff;
  logic [NBANK-1:0] nxt_open;

  // activate set comes after the close so a set is never lost
  always_comb begin
    nxt_open = open_ff;
    if (bank_if.pre_all) begin
      nxt_open = '0;
    end else if (bank_if.pre) begin
      nxt_open[bank_if.bank] = 1'b0;
    end
    if (bank_if.act) begin
      nxt_open[bank_if.bank] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      open_ff <= '0;
    end else if (clk_en_i) begin
      open_ff <= nxt_open;
    end
  end

  assign bank_if.any_open = |open_ff;
endmodule : dcad_bank_trk
`default_nettype wire

// >>> rtl/dcad_pkg.sv
// dcad_pkg: constants and types of the ddr4 command and address input stage
// What this block does
// - capture every command and address input where ck_t rises and ck_c falls
// - cke high enables internal clocks, input buffers, drivers; cke low turns them off
// - cke low enters precharge power-down or self refresh if idle, else active power-down
// - self refresh ends on a cke rise seen without any clock crossing
// - in power-down only clock, odt and cke input buffers stay on
// - in self refresh only the cke input buffer stays on
// - cs_n high masks the command; cs_n is one bit of the command code
// - odt high applies nominal termination; odt ignored when mode register disables it
// - x16 terminates all data lines, both strobe pairs and both mask lines
// - bank address picks the target bank, or the mode register during mode set
// - bank group targets refresh, act, rd, wr, pre; bg0 picks mode register; x16 bg0 only
// - act_n low with cs_n low is activate; we becomes row a14, ras and cas (a16, a15) are dropped
// - act_n high makes ras, cas, we with cs_n the command code bits
// - a10 high on read or write auto-precharges the bank; low keeps row open
// - precharge with a10 high closes all banks; low closes the addressed bank only
// - a12 high on read or write gives full burst; low chops it
// - address is row on activate, column on read or write, op-code on mode set
package dcad_pkg;

  localparam int unsigned ADDR_W     = 14;
  localparam int unsigned ROW_W      = 15;
  localparam int unsigned COL_W      = 10;
  localparam int unsigned BANK_W     = 4;
  localparam int unsigned NBANK      = 16;
  localparam int unsigned DQ_W       = 16;
  localparam int unsigned X8_DQ_W    = 8;
  localparam int unsigned PIN_W      = 27;
  localparam int unsigned SYNC_DEPTH = 2;
  localparam int unsigned AP_BIT     = 10;
  localparam int unsigned BC_BIT     = 12;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_ACT = 4'h1,
    CMD_MRS = 4'h2,
    CMD_REF = 4'h3,
    CMD_PRE = 4'h4,
    CMD_RFU = 4'h5,
    CMD_WR  = 4'h6,
    CMD_RD  = 4'h7,
    CMD_ZQC = 4'h8
  } dcad_cmd_e;

  typedef enum logic [1:0] {
    PS_ACTIVE = 2'h0,
    PS_PPD    = 2'h1,
    PS_APD    = 2'h2,
    PS_SREF   = 2'h3
  } dcad_pwr_e;

  // ras, cas, we code with act_n high
  localparam logic [2:0] OP_MRS = 3'h0;
  localparam logic [2:0] OP_REF = 3'h1;
  localparam logic [2:0] OP_PRE = 3'h2;
  localparam logic [2:0] OP_RFU = 3'h3;
  localparam logic [2:0] OP_WR  = 3'h4;
  localparam logic [2:0] OP_RD  = 3'h5;
  localparam logic [2:0] OP_ZQC = 3'h6;

  localparam dcad_pwr_e RST_PWR    = PS_ACTIVE;
  localparam dcad_cmd_e RST_CMD    = CMD_NOP;
  localparam logic      RST_BUF_EN = 1'b1;
  localparam logic      RST_SYNC   = 1'b0;

endpackage : dcad_pkg

// >>> rtl/dcad_sync.sv
// dcad_sync: two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none
module dcad_sync
  import dcad_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         clk_en_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;

  // first stage feeds the second stage only
  always_comb begin
    nxt_meta = d_i;
    nxt_q    = meta_ff;
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      meta_ff <= {W{RST_SYNC}};
      q_ff    <= {W{RST_SYNC}};
    end else if (clk_en_i) begin
      meta_ff <= nxt_meta;
      q_ff    <= nxt_q;
    end
  end

  assign q_o = q_ff;
endmodule : dcad_sync
`default_nettype wire

// >>> rtl/dcad_top.sv
// dcad_top: ddr4 command/address input stage, decode and power-state control
`timescale 1ns/1ps
`default_nettype none
module dcad_top
  import dcad_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              clk_en_i,
  input  wire logic              ck_t_i,
  input  wire logic              ck_c_i,
  input  wire logic              cke_i,
  input  wire logic              cs_n_i,
  input  wire logic              act_n_i,
  input  wire logic              ras_n_a16_i,
  input  wire logic              cas_n_a15_i,
  input  wire logic              we_n_a14_i,
  input  wire logic              odt_i,
  input  wire logic [1:0]        ba_i,
  input  wire logic [1:0]        bg_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              x16_mode_i,
  input  wire logic              rtt_nom_en_i,
  output logic                   cmd_valid_o,
  output var dcad_cmd_e          cmd_o,
  output logic [1:0]             ba_o,
  output logic [1:0]             bg_o,
  output logic [ROW_W-1:0]       row_o,
  output logic [COL_W-1:0]       col_o,
  output logic [ADDR_W-1:0]      opcode_o,
  output logic [2:0]             mr_sel_o,
  output logic                   auto_pre_o,
  output logic                   burst_chop_o,
  output logic                   pre_all_o,
  output var dcad_pwr_e          pwr_state_o,
  output logic                   int_clk_en_o,
  output logic                   out_drv_en_o,
  output logic                   cmd_buf_en_o,
  output logic                   clk_buf_en_o,
  output logic                   odt_buf_en_o,
  output logic                   cke_buf_en_o,
  output logic                   rtt_nom_on_o,
  output logic [DQ_W-1:0]        term_dq_en_o,
  output logic [1:0]             term_dqs_en_o,
  output logic [1:0]             term_dm_en_o
);

  logic [PIN_W-1:0]  pin_s;
  logic              ck_t_s;
  logic              ck_c_s;
  logic              cke_s;
  logic              cs_s;
  logic              act_s;
  logic              ras_s;
  logic              cas_s;
  logic              we_s;
  logic              odt_s;
  logic [1:0]        ba_s;
  logic [1:0]        bg_s;
  logic [ADDR_W-1:0] addr_s;

  // every pin passes two flops before any decode looks at it
  dcad_sync #(
    .W (PIN_W)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .clk_en_i   (clk_en_i),
    .d_i        ({ck_t_i, ck_c_i, cke_i, cs_n_i, act_n_i, ras_n_a16_i, cas_n_a15_i,
                  we_n_a14_i, odt_i, ba_i, bg_i, addr_i}),
    .q_o        (pin_s)
  );

  assign {ck_t_s, ck_c_s, cke_s, cs_s, act_s, ras_s, cas_s, we_s, odt_s, ba_s, bg_s,
          addr_s} = pin_s;

  dcad_bank_if bank_if ();

  dcad_bank_trk u_bank_trk (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .clk_en_i   (clk_en_i),
    .bank_if    (bank_if)
  );

  logic              ck_cross_ff;
  dcad_pwr_e         state_ff;
  logic              cmd_valid_ff;
  dcad_cmd_e         cmd_ff;
  logic [1:0]        ba_ff;
  logic [1:0]        bg_ff;
  logic [ROW_W-1:0]  row_ff;
  logic [COL_W-1:0]  col_ff;
  logic [ADDR_W-1:0] opcode_ff;
  logic [2:0]        mr_sel_ff;
  logic              auto_pre_ff;
  logic              burst_chop_ff;
  logic              pre_all_ff;
  logic              int_clk_en_ff;
  logic              out_drv_en_ff;
  logic              cmd_buf_en_ff;
  logic              clk_buf_en_ff;
  logic              odt_buf_en_ff;
  logic              cke_buf_en_ff;
  logic              rtt_nom_on_ff;
  logic [DQ_W-1:0]   term_dq_en_ff;
  logic [1:0]        term_dqs_en_ff;
  logic [1:0]        term_dm_en_ff;

  logic              nxt_ck_cross;
  dcad_pwr_e         nxt_state;
  logic              nxt_cmd_valid;
  dcad_cmd_e         nxt_cmd;
  logic [1:0]        nxt_ba;
  logic [1:0]        nxt_bg;
  logic [ROW_W-1:0]  nxt_row;
  logic [COL_W-1:0]  nxt_col;
  logic [ADDR_W-1:0] nxt_opcode;
  logic [2:0]        nxt_mr_sel;
  logic              nxt_auto_pre;
  logic              nxt_burst_chop;
  logic              nxt_pre_all;
  logic              nxt_int_clk_en;
  logic              nxt_out_drv_en;
  logic              nxt_cmd_buf_en;
  logic              nxt_clk_buf_en;
  logic              nxt_odt_buf_en;
  logic              nxt_cke_buf_en;
  logic              nxt_rtt_nom_on;
  logic [DQ_W-1:0]   nxt_term_dq_en;
  logic [1:0]        nxt_term_dqs_en;
  logic [1:0]        nxt_term_dm_en;

  logic              ck_rise;
  logic              take;
  logic              rdwr;
  logic [1:0]        bg_eff;
  dcad_cmd_e         dec;

  // sample point: ck_t high and ck_c low, first cycle of that crossing
  assign ck_rise = ck_t_s & ~ck_c_s & ~ck_cross_ff;
  // x16 has only bg0; bg1 is forced low there
  assign bg_eff  = {bg_s[1] & ~x16_mode_i, bg_s[0]};
  // commands count only with clocks and command buffers running and cke high
  assign take    = ck_rise & (state_ff == PS_ACTIVE) & cke_s & ~cs_s;
  assign rdwr    = (dec == CMD_RD) | (dec == CMD_WR);

  always_comb begin
    dec = CMD_NOP;
    if (!act_s) begin
      dec = CMD_ACT;
    end else begin
      case ({ras_s, cas_s, we_s})
        OP_MRS:  dec = CMD_MRS;
        OP_REF:  dec = CMD_REF;
        OP_PRE:  dec = CMD_PRE;
        OP_RFU:  dec = CMD_RFU;
        OP_WR:   dec = CMD_WR;
        OP_RD:   dec = CMD_RD;
        OP_ZQC:  dec = CMD_ZQC;
        default: dec = CMD_NOP;
      endcase
    end
  end

  // auto-precharge closes the row in the tracker at once; only the power-down choice reads it
  assign bank_if.act     = take & (dec == CMD_ACT);
  assign bank_if.pre     = take & ((dec == CMD_PRE) | (rdwr & addr_s[AP_BIT]));
  assign bank_if.pre_all = take & (dec == CMD_PRE) & addr_s[AP_BIT];
  assign bank_if.bank    = {bg_eff, ba_s};

  // power state
  always_comb begin
    nxt_ck_cross = ck_t_s & ~ck_c_s;
    nxt_state    = state_ff;
    case (state_ff)
      PS_ACTIVE: begin
        if (ck_rise && !cke_s) begin
          if (!cs_s && act_s && dec == CMD_REF && !bank_if.any_open) begin
            nxt_state = PS_SREF;
          end else if (bank_if.any_open) begin
            nxt_state = PS_APD;
          end else begin
            nxt_state = PS_PPD;
          end
        end
      end
      PS_PPD, PS_APD: begin
        if (ck_rise && cke_s) begin
          nxt_state = PS_ACTIVE;
        end
      end
      PS_SREF: begin
        // no clock crossing needed: cke alone ends self refresh
        if (cke_s) begin
          nxt_state = PS_ACTIVE;
        end
      end
      default: nxt_state = PS_ACTIVE;
    endcase
    nxt_int_clk_en = (nxt_state == PS_ACTIVE);
    nxt_out_drv_en = (nxt_state == PS_ACTIVE);
    nxt_cmd_buf_en = (nxt_state == PS_ACTIVE);
    nxt_clk_buf_en = (nxt_state != PS_SREF);
    nxt_odt_buf_en = (nxt_state != PS_SREF);
    nxt_cke_buf_en = 1'b1;
  end

  // command fields; cke staying high over rd/wr is the controller's duty
  always_comb begin
    nxt_cmd_valid  = take;
    nxt_cmd        = cmd_ff;
    nxt_ba         = ba_ff;
    nxt_bg         = bg_ff;
    nxt_row        = row_ff;
    nxt_col        = col_ff;
    nxt_opcode     = opcode_ff;
    nxt_mr_sel     = mr_sel_ff;
    nxt_auto_pre   = auto_pre_ff;
    nxt_burst_chop = burst_chop_ff;
    nxt_pre_all    = pre_all_ff;
    if (take) begin
      nxt_cmd        = dec;
      nxt_ba         = ba_s;
      nxt_bg         = bg_eff;
      // row is a0..a14; a15..a17 are not part of this density
      nxt_row        = {we_s, addr_s};
      nxt_col        = addr_s[COL_W-1:0];
      nxt_opcode     = addr_s;
      nxt_mr_sel     = {bg_s[0], ba_s};
      nxt_auto_pre   = rdwr & addr_s[AP_BIT];
      nxt_burst_chop = rdwr & ~addr_s[BC_BIT];
      nxt_pre_all    = (dec == CMD_PRE) & addr_s[AP_BIT];
    end
  end

  // termination
  always_comb begin
    nxt_rtt_nom_on = rtt_nom_on_ff;
    if (ck_rise) begin
      nxt_rtt_nom_on = odt_s;
    end
    // odt buffer is off from the self refresh entry edge on, not one cycle later
    if (state_ff == PS_SREF || nxt_state == PS_SREF || !rtt_nom_en_i) begin
      nxt_rtt_nom_on = 1'b0;
    end
    nxt_term_dq_en  = '0;
    nxt_term_dqs_en = '0;
    nxt_term_dm_en  = '0;
    if (nxt_rtt_nom_on) begin
      nxt_term_dq_en  = x16_mode_i ? {DQ_W{1'b1}} : {{(DQ_W-X8_DQ_W){1'b0}}, {X8_DQ_W{1'b1}}};
      nxt_term_dqs_en = {x16_mode_i, 1'b1};
      nxt_term_dm_en  = {x16_mode_i, 1'b1};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ck_cross_ff    <= RST_SYNC;
      state_ff       <= RST_PWR;
      cmd_valid_ff   <= 1'b0;
      cmd_ff         <= RST_CMD;
      ba_ff          <= '0;
      bg_ff          <= '0;
      row_ff         <= '0;
      col_ff         <= '0;
      opcode_ff      <= '0;
      mr_sel_ff      <= '0;
      auto_pre_ff    <= 1'b0;
      burst_chop_ff  <= 1'b0;
      pre_all_ff     <= 1'b0;
      int_clk_en_ff  <= RST_BUF_EN;
      out_drv_en_ff  <= RST_BUF_EN;
      cmd_buf_en_ff  <= RST_BUF_EN;
      clk_buf_en_ff  <= RST_BUF_EN;
      odt_buf_en_ff  <= RST_BUF_EN;
      cke_buf_en_ff  <= RST_BUF_EN;
      rtt_nom_on_ff  <= 1'b0;
      term_dq_en_ff  <= '0;
      term_dqs_en_ff <= '0;
      term_dm_en_ff  <= '0;
    end else if (clk_en_i) begin
      ck_cross_ff    <= nxt_ck_cross;
      state_ff       <= nxt_state;
      cmd_valid_ff   <= nxt_cmd_valid;
      cmd_ff         <= nxt_cmd;
      ba_ff          <= nxt_ba;
      bg_ff          <= nxt_bg;
      row_ff         <= nxt_row;
      col_ff         <= nxt_col;
      opcode_ff      <= nxt_opcode;
      mr_sel_ff      <= nxt_mr_sel;
      auto_pre_ff    <= nxt_auto_pre;
      burst_chop_ff  <= nxt_burst_chop;
      pre_all_ff     <= nxt_pre_all;
      int_clk_en_ff  <= nxt_int_clk_en;
      out_drv_en_ff  <= nxt_out_drv_en;
      cmd_buf_en_ff  <= nxt_cmd_buf_en;
      clk_buf_en_ff  <= nxt_clk_buf_en;
      odt_buf_en_ff  <= nxt_odt_buf_en;
      cke_buf_en_ff  <= nxt_cke_buf_en;
      rtt_nom_on_ff  <= nxt_rtt_nom_on;
      term_dq_en_ff  <= nxt_term_dq_en;
      term_dqs_en_ff <= nxt_term_dqs_en;
      term_dm_en_ff  <= nxt_term_dm_en;
    end
  end

  assign cmd_valid_o   = cmd_valid_ff;
  assign cmd_o         = cmd_ff;
  assign ba_o          = ba_ff;
  assign bg_o          = bg_ff;
  assign row_o         = row_ff;
  assign col_o         = col_ff;
  assign opcode_o      = opcode_ff;
  assign mr_sel_o      = mr_sel_ff;
  assign auto_pre_o    = auto_pre_ff;
  assign burst_chop_o  = burst_chop_ff;
  assign pre_all_o     = pre_all_ff;
  assign pwr_state_o   = state_ff;
  assign int_clk_en_o  = int_clk_en_ff;
  assign out_drv_en_o  = out_drv_en_ff;
  assign cmd_buf_en_o  = cmd_buf_en_ff;
  assign clk_buf_en_o  = clk_buf_en_ff;
  assign odt_buf_en_o  = odt_buf_en_ff;
  assign cke_buf_en_o  = cke_buf_en_ff;
  assign rtt_nom_on_o  = rtt_nom_on_ff;
  assign term_dq_en_o  = term_dq_en_ff;
  assign term_dqs_en_o = term_dqs_en_ff;
  assign term_dm_en_o  = term_dm_en_ff;

  // checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_sample_on_cross: assert property (
    cmd_valid_ff && $past(clk_en_i) |-> $past(ck_rise))
    else $error("command taken without a clock crossing");

  a_cs_high_masks: assert property (
    clk_en_i && ck_rise && cs_s |=> !cmd_valid_ff)
    else $error("command taken with cs_n high");

  a_act_row_bits: assert property (
    clk_en_i && take && !act_s |=> cmd_valid_ff && cmd_ff == CMD_ACT
      && row_ff[ROW_W-1] == $past(we_s) && row_ff[ADDR_W-1:0] == $past(addr_s))
    else $error("activate row address wrong");

  a_rd_decode: assert property (
    clk_en_i && take && act_s && {ras_s, cas_s, we_s} == OP_RD |=> cmd_ff == CMD_RD
      && col_ff == $past(addr_s[COL_W-1:0]))
    else $error("read decode or column wrong");

  a_rdwr_autopre: assert property (
    cmd_valid_ff && $past(clk_en_i) && (cmd_ff == CMD_RD || cmd_ff == CMD_WR)
      |-> auto_pre_ff == $past(addr_s[AP_BIT]) && burst_chop_ff == !$past(addr_s[BC_BIT]))
    else $error("auto-precharge or burst chop wrong");

  a_pre_all_bank: assert property (
    cmd_valid_ff && $past(clk_en_i) && cmd_ff == CMD_PRE |-> pre_all_ff == $past(addr_s[AP_BIT]))
    else $error("precharge-all flag wrong");

  a_mrs_select: assert property (
    cmd_valid_ff && $past(clk_en_i) && cmd_ff == CMD_MRS
      |-> mr_sel_ff == {$past(bg_s[0]), $past(ba_s)} && opcode_ff == $past(addr_s))
    else $error("mode register select wrong");

  a_x16_bg1_low: assert property (
    cmd_valid_ff && $past(clk_en_i) && $past(x16_mode_i) |-> !bg_ff[1])
    else $error("bg1 used in x16 mode");

  a_pd_entry_kind: assert property (
    clk_en_i && state_ff == PS_ACTIVE && ck_rise && !cke_s && bank_if.any_open
      |=> state_ff == PS_APD)
    else $error("open bank did not give active power-down");

  a_pd_buffers: assert property (
    state_ff == PS_PPD || state_ff == PS_APD |-> !cmd_buf_en_ff && clk_buf_en_ff
      && odt_buf_en_ff && cke_buf_en_ff && !int_clk_en_ff && !out_drv_en_ff)
    else $error("power-down buffer set wrong");

  a_sref_buffers: assert property (
    state_ff == PS_SREF |-> !cmd_buf_en_ff && !clk_buf_en_ff && !odt_buf_en_ff
      && cke_buf_en_ff && !rtt_nom_on_ff)
    else $error("self refresh buffer set wrong");

  a_sref_exit_cke: assert property (
    clk_en_i && state_ff == PS_SREF && cke_s |=> state_ff == PS_ACTIVE && int_clk_en_ff)
    else $error("self refresh exit missed");

  a_odt_ignored: assert property (
    clk_en_i && !rtt_nom_en_i |=> !rtt_nom_on_ff && term_dq_en_ff == '0)
    else $error("odt honoured while nominal termination disabled");

  a_x16_term_lanes: assert property (
    rtt_nom_on_ff && $past(clk_en_i) && $past(x16_mode_i)
      |-> &term_dq_en_ff && &term_dqs_en_ff && &term_dm_en_ff)
    else $error("x16 termination lanes incomplete");

  c_sref_round: cover property (
    state_ff == PS_ACTIVE ##1 (state_ff == PS_SREF) [*2] ##[1:20] state_ff == PS_ACTIVE);

  c_apd_entry: cover property (bank_if.any_open ##1 state_ff == PS_APD);

  c_rd_autopre: cover property (cmd_valid_ff && cmd_ff == CMD_RD && auto_pre_ff);

  c_wr_chop: cover property (cmd_valid_ff && cmd_ff == CMD_WR && burst_chop_ff);

endmodule : dcad_top
`default_nettype wire

// >>> test/dcad_ctrl_mdl.sv
// dcad_ctrl_mdl: controller-side driver of the command and address pins
`timescale 1ns/1ps
`default_nettype none
module dcad_ctrl_mdl
  import dcad_pkg::*;
(
  input  wire logic         core_clk_i,
  output logic              ck_t_o,
  output logic              ck_c_o,
  output logic              cke_o,
  output logic              cs_n_o,
  output logic              act_n_o,
  output logic [2:0]        rcw_o,
  output logic              odt_o,
  output logic [1:0]        ba_o,
  output logic [1:0]        bg_o,
  output logic [ADDR_W-1:0] addr_o
);
  initial begin
    {ck_t_o, ck_c_o, cke_o, cs_n_o, act_n_o, rcw_o, odt_o} = {5'h0f, 3'h7, 1'b0};
    {ba_o, bg_o, addr_o} = '0;
  end
  // ck stands still between commands; pins held 4 core cycles either side of the
  // crossing because the stage oversamples ck as plain data
  task automatic cmd(input logic k, c, a, input logic [2:0] r, input logic o,
                     input logic [1:0] b, g, input logic [ADDR_W-1:0] ad);
    @(negedge core_clk_i);
    {cke_o, cs_n_o, act_n_o, rcw_o, odt_o, ba_o, bg_o, addr_o} <= {k, c, a, r, o, b, g, ad};
    repeat (4) @(negedge core_clk_i);
    {ck_t_o, ck_c_o} <= 2'h2;
    repeat (4) @(negedge core_clk_i);
    {ck_t_o, ck_c_o} <= 2'h1;
    repeat (2) @(negedge core_clk_i);
  endtask : cmd
  // cke alone rises, no clock crossing at all
  task automatic wake();
    @(negedge core_clk_i);
    cke_o <= 1'b1;
    repeat (6) @(negedge core_clk_i);
  endtask : wake
endmodule : dcad_ctrl_mdl
`default_nettype wire

// >>> test/dcad_top_tb.sv
// dcad_top_tb: self-checking bench of the command/address input stage
`timescale 1ns/1ps
`default_nettype none
module dcad_top_tb
  import dcad_pkg::*;
;
  logic core_clk_i, sys_rst_i, clk_en_i, ck_t_i, ck_c_i, cke_i, cs_n_i, act_n_i, odt_i;
  logic x16_mode_i, rtt_nom_en_i, cmd_valid_o, auto_pre_o, burst_chop_o, pre_all_o;
  logic int_clk_en_o, out_drv_en_o, cmd_buf_en_o, clk_buf_en_o, odt_buf_en_o, cke_buf_en_o;
  logic rtt_nom_on_o;
  logic [2:0]        rcw, mr_sel_o;
  logic [1:0]        ba_i, bg_i, ba_o, bg_o, term_dqs_en_o, term_dm_en_o;
  logic [ADDR_W-1:0] addr_i, opcode_o;
  logic [ROW_W-1:0]  row_o;
  logic [COL_W-1:0]  col_o;
  logic [DQ_W-1:0]   term_dq_en_o;
  dcad_cmd_e         cmd_o;
  dcad_pwr_e         pwr_state_o;
  int                mismatches = 0;
  int                check_count = 0;
  int                npulse = 0;

  dcad_top dcad_top_i (.core_clk_i, .sys_rst_i, .clk_en_i, .ck_t_i, .ck_c_i, .cke_i, .cs_n_i,
    .act_n_i, .ras_n_a16_i(rcw[2]), .cas_n_a15_i(rcw[1]), .we_n_a14_i(rcw[0]), .odt_i, .ba_i,
    .bg_i, .addr_i, .x16_mode_i, .rtt_nom_en_i, .cmd_valid_o, .cmd_o, .ba_o, .bg_o, .row_o,
    .col_o, .opcode_o, .mr_sel_o, .auto_pre_o, .burst_chop_o, .pre_all_o, .pwr_state_o,
    .int_clk_en_o, .out_drv_en_o, .cmd_buf_en_o, .clk_buf_en_o, .odt_buf_en_o,
    .cke_buf_en_o, .rtt_nom_on_o, .term_dq_en_o, .term_dqs_en_o, .term_dm_en_o);
  dcad_ctrl_mdl dcad_ctrl_mdl_i (.core_clk_i, .ck_t_o(ck_t_i), .ck_c_o(ck_c_i), .cke_o(cke_i),
    .cs_n_o(cs_n_i), .act_n_o(act_n_i), .rcw_o(rcw), .odt_o(odt_i), .ba_o(ba_i),
    .bg_o(bg_i), .addr_o(addr_i));

  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) if (cmd_valid_o === 1'b1) npulse <= npulse + 1;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // one crossing, then the count of accepted commands it produced
  task automatic iss(input logic k, c, a, input logic [2:0] r, input logic o,
                     input logic [1:0] b, g, input logic [ADDR_W-1:0] ad, input int n);
    int p0;
    p0 = npulse;
    dcad_ctrl_mdl_i.cmd(k, c, a, r, o, b, g, ad);
    chk(npulse - p0, n);
  endtask : iss

  task automatic t_reset();
    chk(pwr_state_o, PS_ACTIVE);
    chk({int_clk_en_o, out_drv_en_o, cmd_buf_en_o, cke_buf_en_o}, 4'hf);
    chk(cmd_o, CMD_NOP);
    // a crossing while the core is frozen is never seen
    clk_en_i = 1'b0;
    iss(1, 0, 1, OP_RD, 0, 2'h0, 2'h0, 14'h0000, 0);
    clk_en_i = 1'b1;
  endtask : t_reset

  // reads and writes are only issued with cke high
  task automatic t_cmds();
    dcad_cmd_e exp_cmd [7] = '{CMD_MRS, CMD_REF, CMD_PRE, CMD_RFU, CMD_WR, CMD_RD, CMD_ZQC};
    for (int i = 0; i < 7; i++) begin
      iss(1, 0, 1, 3'(i), 0, 2'h0, 2'h0, 14'h0400, 1);
      chk(cmd_o, exp_cmd[i]);
    end
    iss(1, 0, 1, OP_RD, 0, 2'h1, 2'h2, 14'h0601, 1);
    chk({cmd_o, col_o, auto_pre_o, burst_chop_o}, {CMD_RD, 10'h201, 2'h3});
    chk({ba_o, bg_o}, 4'h6);
    iss(1, 0, 1, OP_WR, 0, 2'h3, 2'h1, 14'h13ff, 1);
    chk({cmd_o, col_o, auto_pre_o, burst_chop_o}, {CMD_WR, 10'h3ff, 2'h0});
    iss(1, 1, 1, OP_RD, 0, 2'h0, 2'h0, 14'h0000, 0);
    chk(cmd_o, CMD_WR);
  endtask : t_cmds

  task automatic t_act_mrs();
    iss(1, 0, 0, 3'h5, 0, 2'h2, 2'h3, 14'h2abc, 1);
    chk({cmd_o, row_o, ba_o, bg_o}, {CMD_ACT, 15'h6abc, 4'hb});
    iss(1, 0, 1, OP_MRS, 0, 2'h2, 2'h1, 14'h0155, 1);
    chk({mr_sel_o, opcode_o}, {3'h6, 14'h0155});
  endtask : t_act_mrs

  // a single-bank precharge elsewhere must leave the open row in place
  task automatic t_pd();
    iss(1, 0, 1, OP_PRE, 0, 2'h0, 2'h0, 14'h0000, 1);
    chk(pre_all_o, 1'b0);
    iss(0, 0, 1, 3'h7, 0, 2'h0, 2'h0, 14'h0000, 0);
    chk(pwr_state_o, PS_APD);
    chk({int_clk_en_o, out_drv_en_o, cmd_buf_en_o}, 3'h0);
    chk({clk_buf_en_o, odt_buf_en_o, cke_buf_en_o}, 3'h7);
    iss(0, 0, 1, OP_RD, 0, 2'h0, 2'h0, 14'h0000, 0);
    iss(1, 0, 1, 3'h7, 0, 2'h0, 2'h0, 14'h0000, 0);
    chk(pwr_state_o, PS_ACTIVE);
    iss(1, 0, 1, OP_PRE, 0, 2'h0, 2'h0, 14'h0400, 1);
    chk(pre_all_o, 1'b1);
    iss(0, 0, 1, 3'h7, 0, 2'h0, 2'h0, 14'h0000, 0);
    chk(pwr_state_o, PS_PPD);
    iss(1, 0, 1, 3'h7, 0, 2'h0, 2'h0, 14'h0000, 0);
  endtask : t_pd

  task automatic t_sr();
    iss(0, 0, 1, OP_REF, 1, 2'h0, 2'h0, 14'h0000, 0);
    chk(pwr_state_o, PS_SREF);
    chk({cmd_buf_en_o, clk_buf_en_o, odt_buf_en_o, cke_buf_en_o, rtt_nom_on_o}, 5'h2);
    dcad_ctrl_mdl_i.wake();
    chk(pwr_state_o, PS_ACTIVE);
  endtask : t_sr

  task automatic t_odt();
    x16_mode_i = 1'b1;
    iss(1, 0, 1, OP_RD, 1, 2'h0, 2'h3, 14'h1000, 1);
    chk(bg_o, 2'h1);
    chk({rtt_nom_on_o, term_dq_en_o, term_dqs_en_o, term_dm_en_o}, 21'h1fffff);
    x16_mode_i = 1'b0;
    iss(1, 1, 1, 3'h7, 1, 2'h0, 2'h0, 14'h0000, 0);
    chk({rtt_nom_on_o, term_dq_en_o, term_dqs_en_o, term_dm_en_o}, 21'h100ff5);
    rtt_nom_en_i = 1'b0;
    iss(1, 1, 1, 3'h7, 1, 2'h0, 2'h0, 14'h0000, 0);
    chk({rtt_nom_on_o, term_dq_en_o, term_dqs_en_o, term_dm_en_o}, 21'h0);
  endtask : t_odt

  initial begin
    {sys_rst_i, clk_en_i, x16_mode_i, rtt_nom_en_i} = 4'hd;
    repeat (2) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_cmds();
    t_act_mrs();
    t_pd();
    t_sr();
    t_odt();
    test_done();
  end

  // a full run is some 270 core cycles
  initial begin
    repeat (4000) @(posedge core_clk_i);
    mismatches++;
    test_done();
  end
endmodule : dcad_top_tb
`default_nettype wire
